// [hdl/sas_readout.sv]
// Serial read-out and sample/hold control of the sampling converter
`timescale 1ns/1ns
module sas_readout #(
    parameter int DATA_W_P = sas_pkg::DATA_W
) (
    // Clock and reset
    input  wire logic                          core_clk,
    input  wire logic                          reset_n,
    // Serial pins
    input  wire logic                          cs_n,
    input  wire logic                          serial_conv_clock,
    output      logic                          dout,
    output      logic                          dout_oe,
    // Analog core side
    output      logic                          sample_en,
    output      logic                          conv_start,
    input  wire logic [sas_pkg::DATA_W-1:0]    conv_word,
    input  wire logic                          conv_valid,
    output      logic                          conv_ready
);
    import sas_pkg::*;

    initial begin
        if (DATA_W_P != DATA_W) $error("sas_readout: only the 14-bit frame is supported");
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic cs_meta_reg, cs_sync_reg, cs_prev_reg;
    logic ck_meta_reg, ck_sync_reg, ck_prev_reg;
    logic cs_fall, sclk_fall, sclk_rise;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cs_meta_reg <= 1'b1;
            cs_sync_reg <= 1'b1;
            cs_prev_reg <= 1'b1;
            ck_meta_reg <= 1'b0;
            ck_sync_reg <= 1'b0;
            ck_prev_reg <= 1'b0;
        end else begin
            cs_meta_reg <= cs_n;
            cs_sync_reg <= cs_meta_reg;
            cs_prev_reg <= cs_sync_reg;
            ck_meta_reg <= serial_conv_clock;
            ck_sync_reg <= ck_meta_reg;
            ck_prev_reg <= ck_sync_reg;
        end
    end

    assign cs_fall   = cs_prev_reg && !cs_sync_reg;
    assign sclk_fall = ck_prev_reg && !ck_sync_reg;
    assign sclk_rise = !ck_prev_reg && ck_sync_reg;

    // ------------------------------------------------------------
    // Result buffer
    // ------------------------------------------------------------
    logic              buf_flush, buf_pop, buf_valid;
    logic [DATA_W-1:0] buf_data;

    sas_buf2 #(.W(DATA_W)) u_buf (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .flush     (buf_flush),
        .in_data   (conv_word),
        .in_valid  (conv_valid),
        .in_ready  (conv_ready),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (buf_pop)
    );

    // ------------------------------------------------------------
    // Frame bit selection
    // ------------------------------------------------------------
    function automatic logic bit_at(input logic [5:0] n, input logic [DATA_W-1:0] w);
        logic [FRAME_W-1:0] fr;
        fr = {w, 2'b00};
        bit_at = 1'b0;
        if (n >= MSB_FALL && n < REV_FALL) begin
            bit_at = fr[4'(REV_FALL - 6'h01 - n)];
        end else if (n >= REV_FALL && n < END_FALL) begin
            bit_at = fr[4'(n - REV_FALL)];
        end
    endfunction

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    sas_state_t        state_reg, state_next;
    logic [5:0]        fall_reg, fall_next, fall_inc;
    logic [2:0]        rise_reg, rise_next;
    logic [DATA_W-1:0] word_reg, word_next;
    logic              have_reg, have_next;
    logic              dout_reg, dout_next, oe_reg, oe_next;
    logic              samp_reg, samp_next, start_reg, start_next;

    assign fall_inc = fall_reg + 6'h01;

    always_comb begin
        state_next = state_reg;
        fall_next  = fall_reg;
        rise_next  = rise_reg;
        word_next  = word_reg;
        have_next  = have_reg;
        dout_next  = dout_reg;
        oe_next    = oe_reg;
        samp_next  = samp_reg;
        start_next = 1'b0;
        buf_flush  = 1'b0;
        buf_pop    = 1'b0;
        if (cs_sync_reg) begin
            // Chip select high: tristate and ignore the clock
            state_next = ST_IDLE;
            oe_next    = 1'b0;
            dout_next  = 1'b0;
            samp_next  = 1'b0;
            fall_next  = '0;
            rise_next  = '0;
            have_next  = 1'b0;
        end else if (cs_fall) begin
            // Stale words of an aborted cycle are dropped here
            state_next = ST_SAMPLE;
            samp_next  = 1'b1;
            buf_flush  = 1'b1;
            fall_next  = '0;
            rise_next  = '0;
            have_next  = 1'b0;
        end else if (state_reg != ST_IDLE) begin
            if (state_reg == ST_SAMPLE && sclk_rise) begin
                rise_next = rise_reg + 3'h1;
                if (rise_next == SAMPLE_RISES) begin
                    samp_next  = 1'b0;
                    start_next = 1'b1;
                    state_next = ST_SHIFT;
                end
            end
            if (state_reg == ST_SHIFT && buf_valid && !have_reg) begin
                buf_pop   = 1'b1;
                word_next = buf_data;
                have_next = 1'b1;
            end
            // Output moves on falling edges only; counter saturates after the reverse copy
            if (sclk_fall && fall_reg != END_FALL) begin
                fall_next = fall_inc;
                dout_next = bit_at(fall_inc, have_next ? word_next : '0);
                if (fall_inc == NULL_FALL) begin
                    oe_next = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
            fall_reg  <= '0;
            rise_reg  <= '0;
            word_reg  <= '0;
            have_reg  <= 1'b0;
            dout_reg  <= 1'b0;
            oe_reg    <= 1'b0;
            samp_reg  <= 1'b0;
            start_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            fall_reg  <= fall_next;
            rise_reg  <= rise_next;
            word_reg  <= word_next;
            have_reg  <= have_next;
            dout_reg  <= dout_next;
            oe_reg    <= oe_next;
            samp_reg  <= samp_next;
            start_reg <= start_next;
        end
    end

    assign dout       = dout_reg;
    assign dout_oe    = oe_reg;
    assign sample_en  = samp_reg;
    assign conv_start = start_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    AST_START_ON_CS: assert property (cs_fall |=> sample_en && state_reg == ST_SAMPLE)
        else $error("chip select fall did not start sampling");
    AST_HOLD_AFTER_SAMPLE: assert property ($rose(conv_start) |-> !sample_en && rise_reg == SAMPLE_RISES)
        else $error("hold did not follow the fifth rising edge");
    AST_ISOLATE: assert property (state_reg == ST_SHIFT |-> !sample_en)
        else $error("input still sampled during conversion");
    AST_DOUT_ON_FALL: assert property ($changed(dout) && !cs_sync_reg |-> $past(sclk_fall))
        else $error("output changed without a falling clock edge");
    AST_OE_NULL: assert property ($rose(dout_oe) |-> fall_reg == NULL_FALL && !dout)
        else $error("output enabled at the wrong edge or null bit not low");
    AST_TRISTATE: assert property (cs_sync_reg |=> !dout_oe && state_reg == ST_IDLE)
        else $error("output driven while chip select high");
    AST_MSB_FIRST: assert property (sclk_fall && fall_reg == NULL_FALL && have_reg && !cs_sync_reg && !cs_fall
        |=> dout == word_reg[DATA_W-1])
        else $error("first data bit is not the sign of the current word");
    AST_LSB_REPEAT: assert property (sclk_fall && fall_reg == REV_FALL + 6'h01 && have_reg && !cs_sync_reg
        |=> dout == word_reg[0])
        else $error("reverse copy did not open with the least significant bit");
    AST_DUMMY_ZERO: assert property (sclk_fall && fall_reg == REV_FALL - 6'h02 && !cs_sync_reg
        |=> !dout ##0 $past(fall_reg) == REV_FALL - 6'h02)
        else $error("dummy bit not zero");

    COV_FULL_FRAME: cover property (fall_reg == END_FALL && dout_oe);
    COV_ABORT: cover property (state_reg == ST_SHIFT && fall_reg != END_FALL ##1 cs_sync_reg);
    COV_BUF_FULL: cover property (!conv_ready);
endmodule

// [hdl/sas_pkg.sv]
// Constants shared by the serial read-out logic of the sampling converter
// Behaviour
// - Result shifts out on the serial pin under host clock, most significant bit first.
// - Shifted bits belong to the conversion in progress; no one-cycle latency.
// - Further host clocks after the frame resend the same result least significant first.
// - Conversion start samples the differential input, then isolates inputs until done.
// - Sampling lasts 4.5 converter clock cycles, then the converter holds.
// - Chip select falling starts a conversion and its serial transfer.
// - Serial output bits change only on falling converter clock edges.
// - After fifth falling edge: output enabled, one low bit, sixteen bits ending two zeros.
// - Chip select high tristates output, ignores clocks; restart needs high then low.
package sas_pkg;
    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int          DATA_W       = 14;
    localparam int          FRAME_W      = 16;
    localparam int          SYNC_STAGES  = 2;
    // ------------------------------------------------------------
    // Edge positions counted from chip select falling
    // ------------------------------------------------------------
    localparam logic [2:0]  SAMPLE_RISES = 3'h5;
    localparam logic [5:0]  NULL_FALL    = 6'h05;
    localparam logic [5:0]  MSB_FALL     = 6'h06;
    localparam logic [5:0]  REV_FALL     = 6'h16;
    localparam logic [5:0]  END_FALL     = 6'h26;
    // ------------------------------------------------------------
    // Host clock limits, kept for reference by checkers
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS  = 20;
    localparam int          PHASE_MIN_NS   = 400;
    localparam int          PHASE_MIN_CYC  = (PHASE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          SCLK_MIN_HZ    = 24000;
    localparam int          SCLK_MAX_HZ    = 1200000;
    localparam int          CLKS_PER_CONV  = 24;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [1:0]  BUF_CNT_RST  = 2'h0;
    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_SHIFT} sas_state_t;
endpackage

// [hdl/sas_buf2.sv]
// Two-entry buffer between the conversion core and the serial shifter
`timescale 1ns/1ns
module sas_buf2 #(
    parameter int W = 14
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         reset_n,
    input  wire logic         flush,
    // Filling side
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output      logic         in_ready,
    // Draining side
    output      logic [W-1:0] out_data,
    output      logic         out_valid,
    input  wire logic         out_ready
);
    import sas_pkg::*;

    initial begin
        if (W < 1) $error("sas_buf2: width must be positive");
    end

    logic [W-1:0] mem_reg [2];
    logic [W-1:0] mem_next [2];
    logic         wp_reg, wp_next, rp_reg, rp_next;
    logic [1:0]   cnt_reg, cnt_next;
    logic         rdy_reg, rdy_next;
    logic         push, pop;

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign in_ready  = rdy_reg;
    assign out_valid = (cnt_reg != 2'h0);
    assign out_data  = mem_reg[rp_reg];

    always_comb begin
        mem_next = mem_reg;
        wp_next  = wp_reg;
        rp_next  = rp_reg;
        cnt_next = cnt_reg;
        if (flush) begin
            wp_next  = 1'b0;
            rp_next  = 1'b0;
            cnt_next = BUF_CNT_RST;
        end else begin
            if (push) begin
                mem_next[wp_reg] = in_data;
                wp_next          = ~wp_reg;
            end
            if (pop) begin
                rp_next = ~rp_reg;
            end
            cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
        end
        // Ready is registered so the top-level port leaves a flip-flop
        rdy_next = (cnt_next != 2'h2);
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
            wp_reg     <= 1'b0;
            rp_reg     <= 1'b0;
            cnt_reg    <= BUF_CNT_RST;
            rdy_reg    <= 1'b1;
        end else begin
            mem_reg <= mem_next;
            wp_reg  <= wp_next;
            rp_reg  <= rp_next;
            cnt_reg <= cnt_next;
            rdy_reg <= rdy_next;
        end
    end
endmodule

// [verif/sas_host_model.sv]
// Host-side model: drives chip select and converter clock, samples the serial data
`timescale 1ns/1ns
module sas_host_model (
    // Clock of the sampling process
    input  wire logic        core_clk,
    // Serial pins
    input  wire logic        dout,
    input  wire logic        dout_oe,
    output      logic        cs_n,
    output      logic        serial_conv_clock
);
    logic [63:0] cap_bit;
    logic [63:0] cap_oe;

    initial begin
        cs_n = 1'b1;
        serial_conv_clock = 1'b0;
        cap_bit = '0;
        cap_oe = '0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // Clock stands low outside frames; phases of h >= 20 core cycles keep 400 ns each
    task automatic frame(input int n_clk, input int h);
        wait_cyc(h);
        cs_n = 1'b0;
        for (int i = 1; i <= n_clk; i++) begin
            wait_cyc(h);
            cap_bit[i-1] = dout; // Bit of fall i-1, taken just before rise i
            cap_oe[i-1] = dout_oe;
            serial_conv_clock = 1'b1;
            wait_cyc(h);
            serial_conv_clock = 1'b0;
        end
        wait_cyc(h);
        cap_bit[n_clk] = dout;
        cap_oe[n_clk] = dout_oe;
        cs_n = 1'b1;
    endtask

    // Clocks with chip select high, which must have no effect
    task automatic idle_clocks(input int n, input int h);
        repeat (n) begin
            wait_cyc(h);
            serial_conv_clock = 1'b1;
            wait_cyc(h);
            serial_conv_clock = 1'b0;
        end
    endtask
endmodule

// [verif/sas_readout_tb.sv]
// Self-checking bench for the serial read-out block
`timescale 1ns/1ns
module sas_readout_tb;
    import sas_pkg::*;
    typedef struct {logic [13:0] word; int n_clk; int h;} sas_row_t;
    logic        core_clk;
    logic        reset_n;
    logic        cs_n;
    logic        serial_conv_clock;
    logic        dout;
    logic        dout_oe;
    logic        sample_en;
    logic        conv_start;
    logic [13:0] conv_word;
    logic        conv_valid;
    logic        conv_ready;
    int          num_errors;
    int          cmp_count;
    // Ordinary frames: word, host clocks, half period in core cycles
    sas_row_t rows [5] = '{'{14'h1FFF, 40, 25}, '{14'h2000, 40, 25}, '{14'h0001, 22, 25},
                           '{14'h2AAA, 40, 25}, '{14'h1234, 40, 300}};

    sas_readout i_dut (.core_clk(core_clk), .reset_n(reset_n), .cs_n(cs_n),
        .serial_conv_clock(serial_conv_clock), .dout(dout), .dout_oe(dout_oe), .sample_en(sample_en),
        .conv_start(conv_start), .conv_word(conv_word), .conv_valid(conv_valid), .conv_ready(conv_ready));
    sas_host_model i_host (.core_clk(core_clk), .dout(dout), .dout_oe(dout_oe), .cs_n(cs_n),
        .serial_conv_clock(serial_conv_clock));

    always #10 core_clk = ~core_clk;

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // Word first, two zeros, then whole frame reversed, then zeros
    function automatic logic exp_bit(input logic [13:0] w, input int k);
        if (k >= 6 && k <= 19) return w[19-k];
        if (k >= 24 && k <= 37) return w[k-24];
        return 1'b0;
    endfunction

    task automatic push(input logic [13:0] w);
        int n;
        n = 0;
        @(negedge core_clk);
        conv_word = w;
        conv_valid = 1'b1;
        while (conv_ready !== 1'b1) begin
            @(negedge core_clk);
            n++;
            if (n > 50) begin
                num_errors++;
                complete_run();
            end
        end
        @(negedge core_clk);
        conv_valid = 1'b0;
    endtask

    // Analog core: answers the hold pulse, then offers a second word that must be ignored
    task automatic feed(input logic [13:0] w, input int h);
        int n;
        n = 0;
        while (conv_start !== 1'b1) begin
            @(negedge core_clk);
            n++;
            if (n > 12 * h) begin
                num_errors++;
                complete_run();
            end
        end
        @(negedge core_clk);
        chk(16'(conv_start), 16'h0);
        push(w);
        push(~w);
    endtask

    task automatic measure(input int h);
        int n;
        n = 0;
        while (sample_en !== 1'b1 && n < 2 * h) begin
            @(negedge core_clk);
            n++;
        end
        n = 0;
        while (sample_en === 1'b1 && n < 12 * h) begin
            @(negedge core_clk);
            n++;
        end
        chk(16'(n >= 9 * h - 6 && n <= 9 * h + 6), 16'h1);
    endtask

    task automatic check_frame(input logic [13:0] w, input int n);
        for (int k = 0; k <= n; k++) begin
            chk(16'(i_host.cap_oe[k]), 16'(k >= 5));
            chk(16'(i_host.cap_bit[k]), 16'(exp_bit(w, k)));
        end
    endtask

    initial begin
        core_clk = 1'b0;
        reset_n = 1'b0;
        conv_word = 14'h0000;
        conv_valid = 1'b0;
        num_errors = 0;
        cmp_count = 0;
        repeat (20) @(negedge core_clk);
        chk(16'({dout, dout_oe, sample_en, conv_start, conv_ready}), 16'h0001);
        reset_n = 1'b1;
        foreach (rows[r]) begin
            fork
                i_host.frame(rows[r].n_clk, rows[r].h);
                feed(rows[r].word, rows[r].h);
                measure(rows[r].h);
            join
            check_frame(rows[r].word, rows[r].n_clk);
        end
        // ------------------------------------------------------------
        // Abort in mid-word, then clocks without chip select
        // ------------------------------------------------------------
        fork
            i_host.frame(12, 25);
            feed(14'h3FFF, 25);
        join
        check_frame(14'h3FFF, 12);
        repeat (6) @(negedge core_clk);
        chk(16'({dout_oe, dout}), 16'h0000);
        i_host.idle_clocks(8, 25);
        chk(16'({dout_oe, dout, sample_en}), 16'h0000);
        // ------------------------------------------------------------
        // Buffer full refuses; next conversion flushes stale words
        // ------------------------------------------------------------
        // The aborted frame left its spare word behind; one more push fills the buffer
        push(14'h0AAA);
        repeat (2) @(negedge core_clk);
        chk(16'(conv_ready), 16'h0000);
        conv_word = 14'h3333;
        conv_valid = 1'b1;
        repeat (4) @(negedge core_clk);
        chk(16'(conv_ready), 16'h0000);
        conv_valid = 1'b0;
        fork
            i_host.frame(40, 25);
            feed(14'h0F0F, 25);
        join
        check_frame(14'h0F0F, 40);
        complete_run();
    end
endmodule
